// *** inc/adcso_defs.svh ***
// constants of the serial output configuration bank
// assumes inclusion by bare name from inc/
`ifndef ADCSO_DEFS_SVH
`define ADCSO_DEFS_SVH
// register addresses (13-bit serial port address space)
`define ADCSO_ADDR_DEVICE_INDEX  13'h005
`define ADCSO_ADDR_OUT_ADJUST    13'h015
`define ADCSO_ADDR_OUT_PHASE     13'h016
`define ADCSO_ADDR_SER_CTRL      13'h021
`define ADCSO_ADDR_TRANSFER      13'h0FF
`define ADCSO_ADDR_OVERRIDE      13'h100
`define ADCSO_ADDR_USER_IO_TWO   13'h101
`define ADCSO_ADDR_USER_IO_THREE 13'h102
// reset values
`define ADCSO_RST_DEVICE_INDEX   8'h0F
`define ADCSO_RST_OUT_ADJUST     8'h00
`define ADCSO_RST_OUT_PHASE      8'h03
`define ADCSO_RST_SER_CTRL       8'h30
`define ADCSO_RST_OVERRIDE       8'h00
`define ADCSO_RST_USER_IO        8'h00
`define ADCSO_RST_PH_CODE        4'h3
// field positions
`define ADCSO_ADJ_DRIVE_BIT      0
`define ADCSO_ADJ_TERM_LSB       4
`define ADCSO_PH_OUT_LSB         0
`define ADCSO_PH_IN_LSB          4
`define ADCSO_SC_WORD12_BIT      1
`define ADCSO_SC_FRAME2X_BIT     2
`define ADCSO_SC_DDR_BIT         5
`define ADCSO_SC_ONELANE_BIT     6
`define ADCSO_XFER_BIT           0
`define ADCSO_IO2_PULLDOWN_BIT   0
`define ADCSO_IO3_VCMPD_BIT      3
`define ADCSO_DIX_CLK_LSB        4
// output phase codes 0000..1011 are legal; step is 60 degrees
`define ADCSO_PH_OUT_MAX         4'hB
`define ADCSO_PH_STEP_DEG        60
// data clock multipliers
`define ADCSO_MULT_16_DDR2       4'h4
`define ADCSO_MULT_16_OTHER      4'h8
`define ADCSO_MULT_12_DDR2       4'h3
`define ADCSO_MULT_12_OTHER      4'h6
`endif

// *** inc/adcso_pkg.sv ***
// types of the serial output configuration bank
// assumes adcso_defs.svh for constants
package adcso_pkg;
  typedef logic [7:0]  adcso_byte_t;
  typedef logic [12:0] adcso_addr_t;
endpackage : adcso_pkg

// *** logic/adcso_mode_dec.sv ***
// serialization mode decoder: data clock multiplier and mode flags
// assumes a stable control byte; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "adcso_defs.svh"
module adcso_mode_dec (
  // control value
  input  wire logic [7:0] ser_ctrl_i,
  // decoded mode
  output logic      [3:0] dco_mult_o,
  output logic            word12_o,
  output logic            frame2x_o,
  output logic            ddr_o,
  output logic            one_lane_o
);
  import adcso_pkg::*;
  // ==========================================================
  // decode
  always_comb begin
    word12_o   = ser_ctrl_i[`ADCSO_SC_WORD12_BIT];
    frame2x_o  = ser_ctrl_i[`ADCSO_SC_FRAME2X_BIT];
    one_lane_o = ser_ctrl_i[`ADCSO_SC_ONELANE_BIT];
    // one-lane is always ddr; two-lane follows bit 5
    ddr_o      = ser_ctrl_i[`ADCSO_SC_DDR_BIT] | one_lane_o;
    // sdr or one lane doubles the clock ratio
    if (word12_o) begin // RL13
      dco_mult_o = (ddr_o && !one_lane_o) ? `ADCSO_MULT_12_DDR2
                                          : `ADCSO_MULT_12_OTHER;
    end else begin
      dco_mult_o = (ddr_o && !one_lane_o) ? `ADCSO_MULT_16_DDR2
                                          : `ADCSO_MULT_16_OTHER;
    end
  end
endmodule : adcso_mode_dec
`default_nettype wire

// *** logic/adcso_regs.sv ***
// serial output configuration register bank
// assumes a serial-port front end giving one-cycle write/read strobes
// assumes address and data stand with the strobe for its one cycle
// assumes the host keeps the input phase within the divider ratio
// Behaviour
// [RL1] drive bit sets clock outputs 1x or 2x
// [RL2] host selects clock channel before drive
// [RL3] termination overrides double drive
// [RL4] two-bit field picks termination resistor
// [RL5] input phase delays sample under division
// [RL6] host keeps input phase within divider
// [RL7] output clock phase code times 60
// [RL8] override waits for transfer bit
// [RL9] override caps capability, not sample rate
// [RL10] bit disconnects data pin pull-down
// [RL11] bit powers down common-mode generator
// [RL12] control value selects serialization mode
// [RL13] data clock fixed multiple of sample
// [RL14] override lets user lower power
// [RL15] other registers take effect at once
// [RL16] clock settings apply to selected channels
`timescale 1ns/1ps
`default_nettype none
`include "adcso_defs.svh"
module adcso_regs #(
  parameter int NUM_CLK_CH = 2,
  parameter int NUM_DAT_CH = 4
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // register port
  input  wire logic                  wr_en_i,
  input  wire logic                  rd_en_i,
  input  wire adcso_pkg::adcso_addr_t addr_i,
  input  wire adcso_pkg::adcso_byte_t wdata_i,
  output logic                  [7:0] rdata_o,
  output logic                        rvalid_o,
  // clock output channel controls
  output logic     [NUM_CLK_CH-1:0] clk_drive_2x_o,
  output logic   [2*NUM_CLK_CH-1:0] clk_term_o,
  output logic   [4*NUM_DAT_CH-1:0] out_phase_o,
  output logic                [2:0] in_phase_o,
  // serialization mode
  output logic                [7:0] ser_ctrl_o,
  output logic                [3:0] dco_mult_o,
  // applied override and pins
  output logic                [7:0] override_o,
  output logic                      pulldown_off_o,
  output logic                      vcm_pd_o
);
  import adcso_pkg::*;

  // ==========================================================
  // parameter check
  // the device index carries four data and four clock select bits,
  // so no larger count could ever be selected
  if (NUM_CLK_CH < 1 || NUM_CLK_CH > 4 || NUM_DAT_CH < 1 ||
      NUM_DAT_CH > 4) begin : g_bad_counts
    $error("channel counts must be 1 to 4");
  end

  // ==========================================================
  // state record: every flop of the bank
  typedef struct packed {
    // host settings, live as soon as written
    logic [7:0]              dev_index;
    logic [NUM_CLK_CH-1:0]   drive;
    logic [2*NUM_CLK_CH-1:0] term;
    logic [4*NUM_DAT_CH-1:0] ph_out;
    logic [2:0]              ph_in;
    logic [7:0]              ser_ctrl;
    // override pair: host writes the shadow, transfer makes it active
    logic [7:0]              ovr_shadow;
    logic [7:0]              ovr_active;
    logic                    pulldown_off;
    logic                    vcm_pd;
    // read answer
    logic [7:0]              rdata;
    logic                    rvalid;
    // derived values, held in flops so ports come straight from flops
    logic [NUM_CLK_CH-1:0]   drive2x;
    logic [3:0]              mult;
  } adcso_state_t;

  adcso_state_t s_q;
  adcso_state_t s_d;
  logic [3:0]   mult_dec;

  // ==========================================================
  // mode decode
  adcso_mode_dec u_dec (
    .ser_ctrl_i (s_q.ser_ctrl),
    .dco_mult_o (mult_dec),
    .word12_o   (),
    .frame2x_o  (),
    .ddr_o      (),
    .one_lane_o ()
  );

  // selection of clock channel c by the device index
  // clock select bits sit above the four data select bits
  function automatic logic clk_sel(input logic [7:0] idx, input int c);
    clk_sel = idx[`ADCSO_DIX_CLK_LSB + c];
  endfunction : clk_sel

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    // the read answer is a one-cycle pulse
    s_d.rvalid = 1'b0;
    // writes land at once; only the override waits for a transfer
    if (wr_en_i) begin
      unique case (addr_i)
        `ADCSO_ADDR_DEVICE_INDEX: s_d.dev_index = wdata_i;
        // unselected clock channels keep their drive and termination
        `ADCSO_ADDR_OUT_ADJUST: begin
          for (int c = 0; c < NUM_CLK_CH; c++) begin
            if (clk_sel(s_q.dev_index, c)) begin // RL16 RL2
              s_d.drive[c] = wdata_i[`ADCSO_ADJ_DRIVE_BIT]; // RL1
              s_d.term[2*c +: 2] =
                wdata_i[`ADCSO_ADJ_TERM_LSB +: 2]; // RL4
            end
          end
        end
        `ADCSO_ADDR_OUT_PHASE: begin
          // the divider ratio lives outside this bank, so the input
          // phase is stored as written; its range is the host's duty
          s_d.ph_in = wdata_i[`ADCSO_PH_IN_LSB +: 3]; // RL5 RL6
          for (int d = 0; d < NUM_DAT_CH; d++) begin
            // codes above 1011 are not applied
            if (s_q.dev_index[d] &&
                wdata_i[3:0] <= `ADCSO_PH_OUT_MAX) begin // RL16
              s_d.ph_out[4*d +: 4] = wdata_i[3:0]; // RL7
            end
          end
        end
        `ADCSO_ADDR_SER_CTRL: s_d.ser_ctrl = wdata_i; // RL12 RL15
        // only the transfer copies the shadow, so a half-written
        // operating point never reaches the converter
        `ADCSO_ADDR_TRANSFER: begin
          if (wdata_i[`ADCSO_XFER_BIT]) begin
            s_d.ovr_active = s_q.ovr_shadow; // RL8 RL14
          end
        end
        `ADCSO_ADDR_OVERRIDE: s_d.ovr_shadow = wdata_i; // RL8
        `ADCSO_ADDR_USER_IO_TWO:
          s_d.pulldown_off = wdata_i[`ADCSO_IO2_PULLDOWN_BIT]; // RL10
        `ADCSO_ADDR_USER_IO_THREE:
          s_d.vcm_pd = wdata_i[`ADCSO_IO3_VCMPD_BIT]; // RL11
        default: ;
      endcase
    end
    // termination present wins over double drive
    // taken from the next state so the port moves with the write
    for (int c = 0; c < NUM_CLK_CH; c++) begin
      s_d.drive2x[c] = s_d.drive[c] &&
                       (s_d.term[2*c +: 2] == 2'h0); // RL3 RL1
    end
    // the multiplier lags the control byte by one cycle, because the
    // decoder reads the registered byte
    s_d.mult = mult_dec; // RL13
    // a read in the cycle of a write to the same address sees the old
    // value, as the answer is taken from the current state
    if (rd_en_i) begin
      s_d.rvalid = 1'b1;
      unique case (addr_i)
        `ADCSO_ADDR_DEVICE_INDEX: s_d.rdata = s_q.dev_index;
        `ADCSO_ADDR_OUT_ADJUST:
          s_d.rdata = {2'h0, s_q.term[1:0], 3'h0, s_q.drive[0]};
        `ADCSO_ADDR_OUT_PHASE:
          s_d.rdata = {1'b0, s_q.ph_in, s_q.ph_out[3:0]};
        `ADCSO_ADDR_SER_CTRL: s_d.rdata = s_q.ser_ctrl;
        `ADCSO_ADDR_OVERRIDE: s_d.rdata = s_q.ovr_shadow;
        `ADCSO_ADDR_USER_IO_TWO: s_d.rdata = {7'h00, s_q.pulldown_off};
        `ADCSO_ADDR_USER_IO_THREE:
          s_d.rdata = {4'h0, s_q.vcm_pd, 3'h0};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    // reset image: constants only
    if (!reset_n_i) begin
      s_q.dev_index    <= `ADCSO_RST_DEVICE_INDEX;
      s_q.drive        <= '0;
      s_q.term         <= '0;
      s_q.ph_out       <= {NUM_DAT_CH{`ADCSO_RST_PH_CODE}};
      s_q.ph_in        <= 3'h0;
      s_q.ser_ctrl     <= `ADCSO_RST_SER_CTRL;
      s_q.ovr_shadow   <= `ADCSO_RST_OVERRIDE;
      s_q.ovr_active   <= `ADCSO_RST_OVERRIDE;
      s_q.pulldown_off <= 1'b0;
      s_q.vcm_pd       <= 1'b0;
      s_q.rdata        <= 8'h00;
      s_q.rvalid       <= 1'b0;
      s_q.drive2x      <= '0;
      s_q.mult         <= `ADCSO_MULT_16_DDR2;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign rdata_o        = s_q.rdata;
  assign rvalid_o       = s_q.rvalid;
  assign clk_drive_2x_o = s_q.drive2x;
  assign clk_term_o     = s_q.term;
  assign out_phase_o    = s_q.ph_out;
  assign in_phase_o     = s_q.ph_in;
  assign ser_ctrl_o     = s_q.ser_ctrl;
  assign dco_mult_o     = s_q.mult;
  // the override never feeds the multiplier: it caps capability only
  assign override_o     = s_q.ovr_active; // RL9
  assign pulldown_off_o = s_q.pulldown_off;
  assign vcm_pd_o       = s_q.vcm_pd;
endmodule : adcso_regs
`default_nettype wire

// *** tb/adcso_capture.sv ***
// data capture model at the far side of the serial outputs
// assumes the bank's data clock multiplier sets its capture ratio
`timescale 1ns/1ps
`default_nettype none
module adcso_capture (
  // clock, reset, ratio in
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] dco_mult_i,
  // ratio in use
  output logic      [3:0] ratio_o
);
  // receiver follows the device ratio; only reset loads a ratio of its own, 4
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ratio_o <= 4'h4;
    else ratio_o <= dco_mult_i;
  end
endmodule : adcso_capture
`default_nettype wire

// *** tb/adcso_regs_assertions.sv ***
// checker of the serial output configuration bank
// assumes a bind onto adcso_regs, ports by name
`timescale 1ns/1ps
`default_nettype none
module adcso_chk #(
  parameter int NUM_CLK_CH = 2,
  parameter int NUM_DAT_CH = 4
) (
  // watched ports
  input wire logic sys_clk_i, reset_n_i, wr_en_i, rd_en_i,
  input wire adcso_pkg::adcso_addr_t addr_i,
  input wire adcso_pkg::adcso_byte_t wdata_i,
  input wire logic [7:0] rdata_o, ser_ctrl_o, override_o,
  input wire logic rvalid_o, pulldown_off_o, vcm_pd_o,
  input wire logic [NUM_CLK_CH-1:0] clk_drive_2x_o,
  input wire logic [2*NUM_CLK_CH-1:0] clk_term_o,
  input wire logic [4*NUM_DAT_CH-1:0] out_phase_o,
  input wire logic [2:0] in_phase_o,
  input wire logic [3:0] dco_mult_o
);
  // ==========
  // multiplier of a control byte; one-lane counts as not two-lane
  function automatic logic [3:0] mult_f(input logic [7:0] c);
    mult_f = c[1] ? ((c[5] & ~c[6]) ? 4'h3 : 4'h6)
                  : ((c[5] & ~c[6]) ? 4'h4 : 4'h8);
  endfunction : mult_f
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  read_answer_a: assert property (
    rvalid_o == $past(rd_en_i))
    else $error("read answer timing wrong");
  mode_mult_a: assert property (
    ##1 dco_mult_o == mult_f($past(ser_ctrl_o)))
    else $error("data clock multiplier wrong");
  term_wins_a: assert property (
    clk_term_o[1:0] != 2'h0 |-> !clk_drive_2x_o[0])
    else $error("double drive with termination");
  ovr_hold_a: assert property (
    !(wr_en_i && addr_i == 13'h0FF && wdata_i[0])
    |=> $stable(override_o))
    else $error("override moved without transfer");
  ser_write_a: assert property (
    wr_en_i && addr_i == 13'h021
    |=> ser_ctrl_o == $past(wdata_i))
    else $error("serial control not written");
  pull_down_a: assert property (
    wr_en_i && addr_i == 13'h101
    |=> pulldown_off_o == $past(wdata_i[0]))
    else $error("pull-down control wrong");
  vcm_off_a: assert property (
    wr_en_i && addr_i == 13'h102
    |=> vcm_pd_o == $past(wdata_i[3]))
    else $error("common-mode control wrong");
  phase_range_a: assert property (
    wr_en_i && addr_i == 13'h016 && wdata_i[3:0] > 4'hB
    |=> $stable(out_phase_o))
    else $error("illegal phase code taken");
  cover property (rvalid_o);
  cover property (wr_en_i && addr_i == 13'h0FF && wdata_i[0]);
  cover property (clk_drive_2x_o[0]);
endmodule : adcso_chk
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the serial output configuration bank
// assumes adcso_regs with two clock and four data channels
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adcso_pkg::*;
  logic sys_clk_i = 0, reset_n_i = 0, wr_en_i = 0, rd_en_i = 0;
  adcso_addr_t addr_i = '0;
  adcso_byte_t wdata_i = '0;
  logic [7:0]  rdata_o, ser_ctrl_o, override_o;
  logic        rvalid_o, pulldown_off_o, vcm_pd_o;
  logic [1:0]  clk_drive_2x_o;
  logic [3:0]  clk_term_o, dco_mult_o;
  logic [15:0] out_phase_o;
  logic [2:0]  in_phase_o;
  logic [3:0]  ratio;
  int          error_cnt = 0, check_count = 0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'hCE867D02;
  logic [7:0]  codes[8] = '{8'h30, 8'h10, 8'h40, 8'h42,
                            8'h32, 8'h02, 8'h34, 8'h06};
  logic [3:0]  mults[8] = '{4'h4, 4'h8, 4'h8, 4'h6,
                            4'h3, 4'h6, 4'h4, 4'h6};
  // ==========
  always #2 sys_clk_i = ~sys_clk_i;
  adcso_regs uut (
    .sys_clk_i      (sys_clk_i),
    .reset_n_i      (reset_n_i),
    .wr_en_i        (wr_en_i),
    .rd_en_i        (rd_en_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .rdata_o        (rdata_o),
    .rvalid_o       (rvalid_o),
    .clk_drive_2x_o (clk_drive_2x_o),
    .clk_term_o     (clk_term_o),
    .out_phase_o    (out_phase_o),
    .in_phase_o     (in_phase_o),
    .ser_ctrl_o     (ser_ctrl_o),
    .dco_mult_o     (dco_mult_o),
    .override_o     (override_o),
    .pulldown_off_o (pulldown_off_o),
    .vcm_pd_o       (vcm_pd_o)
  );
  adcso_capture partner (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
                         .dco_mult_i(dco_mult_o), .ratio_o(ratio));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1 wr_en_i = 1;
    addr_i = a;
    wdata_i = d;
    @(posedge sys_clk_i);
    #1 wr_en_i = 0;
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    #1 rd_en_i = 1;
    addr_i = a;
    @(posedge sys_clk_i);
    #1 rd_en_i = 0;
  endtask : rd
  task automatic results;
    // a read that never answered counts against the run
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("mismatch pending_reads expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // read monitor: sampled mid-cycle, well clear of the edge
  always @(negedge sys_clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("mismatch rvalid expected 0 seen 1");
      end else begin
        chk("rdata", exp_q.pop_front(), {8'h00, rdata_o});
      end
    end
  end
  initial begin
    #20000 error_cnt++;
    results();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 reset_n_i = 1;
    chk("ser_ctrl", 8'h30, ser_ctrl_o);
    chk("out_phase", 16'h3333, out_phase_o);
    chk("drive", 2'h0, clk_drive_2x_o);
    rd(13'h021, 8'h30);
    rd(13'h016, 8'h03);
    rd(13'h1FF, 8'h00);
    // the receiver follows one cycle behind the multiplier
    for (int i = 0; i < 8; i++) begin
      wr(13'h021, codes[i]);
      @(posedge sys_clk_i);
      #1 chk("mult", mults[i], dco_mult_o);
      @(posedge sys_clk_i);
      #1 chk("ratio", mults[i], ratio);
    end
    wr(13'h005, 8'h30);
    wr(13'h015, 8'h01);
    chk("drive", 2'h3, clk_drive_2x_o);
    wr(13'h015, 8'h11);
    chk("drive", 2'h0, clk_drive_2x_o);
    chk("term", 4'h5, clk_term_o);
    rd(13'h015, 8'h11);
    wr(13'h005, 8'h01);
    // the divider sits outside the bank; phase 4 stays within its ratio
    wr(13'h016, 8'h45);
    chk("out_phase", 16'h3335, out_phase_o);
    chk("in_phase", 3'h4, in_phase_o);
    wr(13'h016, 8'h0C);
    chk("out_phase", 16'h3335, out_phase_o);
    wr(13'h100, 8'h25);
    chk("override", 8'h00, override_o);
    wr(13'h0FF, 8'h01);
    chk("override", 8'h25, override_o);
    chk("mult", 4'h6, dco_mult_o);
    wr(13'h101, 8'h01);
    chk("pulldown", 1'b1, pulldown_off_o);
    wr(13'h102, 8'h08);
    chk("vcm", 1'b1, vcm_pd_o);
    repeat (4) begin
      seed = lfsr(seed);
      wr(13'h021, seed[7:0] & 8'h76);
      rd(13'h021, seed[7:0] & 8'h76);
    end
    repeat (3) @(posedge sys_clk_i);
    results();
  end
endmodule : tb
bind adcso_regs adcso_chk #(.NUM_CLK_CH(NUM_CLK_CH),
  .NUM_DAT_CH(NUM_DAT_CH)) chk (
  .sys_clk_i      (sys_clk_i),
  .reset_n_i      (reset_n_i),
  .wr_en_i        (wr_en_i),
  .rd_en_i        (rd_en_i),
  .addr_i         (addr_i),
  .wdata_i        (wdata_i),
  .rdata_o        (rdata_o),
  .ser_ctrl_o     (ser_ctrl_o),
  .override_o     (override_o),
  .rvalid_o       (rvalid_o),
  .pulldown_off_o (pulldown_off_o),
  .vcm_pd_o       (vcm_pd_o),
  .clk_drive_2x_o (clk_drive_2x_o),
  .clk_term_o     (clk_term_o),
  .out_phase_o    (out_phase_o),
  .in_phase_o     (in_phase_o),
  .dco_mult_o     (dco_mult_o)
);
`default_nettype wire
